// ### logic/rss_defines.svh
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// Pin roles fixed in silicon
`define RSS_PORT_SEL_PIN    9
`define RSS_HOLD_HIGH_PIN   8

// Default configuration-select pins when none are assigned: GPIO[3:0]
`define RSS_DEF_SEL_MASK    4'hF

// Default pin counts
`define RSS_DEF_NGPIO       16
`define RSS_DEF_NCLK        8

// Reset values of the derived settings and of the clock and GPIO output enables
`define RSS_RST_MAIN_I2C    1'b0
`define RSS_RST_A2          1'b0
`define RSS_RST_EEPROM_EN   1'b1
`define RSS_RST_CLK_OUT_EN  1'b0
`define RSS_RST_GPIO_OUT_EN 1'b0

`endif

// ### logic/rss_pkg.sv
package rss_pkg;

  // Gray-coded along idle -> in reset -> capture -> held
  typedef enum logic [1:0] {
    RSS_ST_IDLE    = 2'b00,
    RSS_ST_RESET   = 2'b01,
    RSS_ST_CAPTURE = 2'b11,
    RSS_ST_HELD    = 2'b10
  } rss_state_t;

endpackage

// ### logic/rss_sel_if.sv
interface rss_sel_if #(
  parameter int NG = 16
);
  logic [NG-1:0] strap;
  logic [NG-1:0] addr_mask;
  logic [NG-1:0] eeprom_mask;
  logic [NG-1:0] sel_mask;
  logic          a2;
  logic          eeprom_dis;
  logic [NG-1:0] index;

  modport calc (
    input  strap,
    input  addr_mask,
    input  eeprom_mask,
    input  sel_mask,
    output a2,
    output eeprom_dis,
    output index
  );

  modport user (
    output strap,
    output addr_mask,
    output eeprom_mask,
    output sel_mask,
    input  a2,
    input  eeprom_dis,
    input  index
  );
endinterface

// ### logic/rss_select.sv
module rss_select
  import rss_pkg::*;
#(
  parameter int NG = 16
) (
  rss_sel_if.calc sif
);

  localparam int CW = $clog2(NG + 1);

  logic [CW-1:0] sel_cnt   [NG+1];
  logic [NG-1:0] sel_acc   [NG+1];
  logic [NG:0]   a2_chain;

  assign sel_cnt[0]  = '0;
  assign sel_acc[0]  = '0;
  // No pin assigned leaves A2 at zero
  assign a2_chain[0] = 1'b0;   // [R5]

  genvar i;
  generate
    for (i = 0; i < NG; i++) begin : g_pin
      wire           sel_hit = sif.sel_mask[i] & sif.strap[i];
      wire [NG-1:0]  sel_bit = sel_hit ? (NG'(1) << sel_cnt[i]) : '0;
      // Each assigned pin lands at the count of assigned pins below it
      assign sel_cnt[i+1]  = sel_cnt[i] + CW'(sif.sel_mask[i]);   // [R13] [R15]
      assign sel_acc[i+1]  = sel_acc[i] | sel_bit;                // [R13] [R14]
      // Higher index overrides lower ones along the chain
      assign a2_chain[i+1] = sif.addr_mask[i] ? sif.strap[i] : a2_chain[i];   // [R5] [R6]
    end
  endgenerate

  assign sif.index      = sel_acc[NG];
  assign sif.a2         = a2_chain[NG];
  assign sif.eeprom_dis = |(sif.eeprom_mask & sif.strap);   // [R8] [R10]

endmodule

// ### logic/rss_top.sv
// What this block does
// [R1] Capture every GPIO level at master reset rise; derive start-up settings from it.
// [R2] Pin 9 low: main SPI, aux I2C; high: main I2C, aux SPI.
// [R3] Board keeps pin 8 high throughout master reset assertion.
// [R4] All strap-derived settings stay writable afterwards through write ports.
// [R5] No address pin assigned gives A2 zero; else A2 from that pin.
// [R6] Several address pins: only the highest-index one counts.
// [R7] A2 applies only to the I2C port, never to the SPI port.
// [R8] High on an EEPROM-disable pin stops the external EEPROM search.
// [R9] No EEPROM-disable pin assigned: EEPROM search always enabled.
// [R10] Several EEPROM-disable pins combine by logical OR.
// [R11] No select pins assigned: index comes from GPIO 3 down to 0.
// [R12] Pulled-up default select pins give index fifteen.
// [R13] Up to four select pins, ascending index, lowest pin is LSB.
// [R14] Fewer than four select pins fill a 4-bit index, upper bits zero.
// [R15] More than four select pins form a correspondingly wider index.
// [R16] Without stored user configs index is ignored, default pin roles kept.
// [R17] Defaults: all clock outputs off, all GPIOs general-purpose inputs.
// [R18] Board should not use test-access GPIOs for strap functions.
// [R19] Checksum failure skips the load; registers keep default values.
// [R20] Captured straps stay constant until master reset asserts again.
`include "rss_defines.svh"

module rss_top
  import rss_pkg::*;
#(
  parameter int NG = `RSS_DEF_NGPIO,
  parameter int NC = `RSS_DEF_NCLK
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          master_reset_low,
  input  wire logic [NG-1:0] gpio_pin_in,
  input  wire logic [NG-1:0] info_addr_mask,
  input  wire logic [NG-1:0] info_eeprom_dis_mask,
  input  wire logic [NG-1:0] info_cfg_sel_mask,
  input  wire logic          info_has_user_cfg,
  input  wire logic          cfg_check_done,
  input  wire logic          cfg_check_ok,
  input  wire logic          wr_port_swap_we,
  input  wire logic          wr_port_swap,
  input  wire logic          wr_a2_we,
  input  wire logic          wr_a2,
  input  wire logic          wr_eeprom_en_we,
  input  wire logic          wr_eeprom_en,
  input  wire logic          wr_index_we,
  input  wire logic [NG-1:0] wr_index,
  input  wire logic          wr_clk_out_we,
  input  wire logic [NC-1:0] wr_clk_out_en,
  input  wire logic          wr_gpio_mode_we,
  input  wire logic [NG-1:0] wr_gpio_out_en,
  output logic               main_is_i2c,
  output logic               aux_is_i2c,
  output logic               main_addr_a2,
  output logic               aux_addr_a2,
  output logic               eeprom_search_en,
  output logic [NG-1:0]      cfg_index,
  output logic               cfg_index_valid,
  output logic               cfg_load_en,
  output logic               cfg_load_skipped,
  output logic               strap_captured,
  output logic               hold_pin_fault,
  output logic [NC-1:0]      clk_out_en,
  output logic [NG-1:0]      gpio_out_en
);

  if (NG <= `RSS_PORT_SEL_PIN || NG < 4 || NC < 1) begin : g_bad_param
    $error("rss_top: NG must exceed the port-select pin and be at least 4, NC at least 1");
  end

  // Pin synchronisers; stage one is read only by stage two
  logic          mr_s1_reg;
  logic          mr_s2_reg;
  logic          mr_d_reg;
  logic [NG-1:0] gpio_s1_reg;
  logic [NG-1:0] gpio_s2_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      // Idle level of the pin, so no false rise follows srst
      mr_s1_reg   <= 1'b1;
      mr_s2_reg   <= 1'b1;
      mr_d_reg    <= 1'b1;
      gpio_s1_reg <= '0;
      gpio_s2_reg <= '0;
    end else begin
      mr_s1_reg   <= master_reset_low;
      mr_s2_reg   <= mr_s1_reg;
      mr_d_reg    <= mr_s2_reg;
      gpio_s1_reg <= gpio_pin_in;
      gpio_s2_reg <= gpio_s1_reg;
    end
  end

  // Both pin paths share the same delay, so levels line up with the edge
  wire mr_rise = mr_s2_reg & ~mr_d_reg;
  wire mr_low  = ~mr_s2_reg;

  rss_state_t    state_reg;
  rss_state_t    state_next;
  logic [NG-1:0] strap_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RSS_ST_IDLE: begin
        if (mr_low) begin
          state_next = RSS_ST_RESET;
        end
      end
      RSS_ST_RESET: begin
        if (mr_rise) begin
          state_next = RSS_ST_CAPTURE;
        end
      end
      RSS_ST_CAPTURE: begin
        state_next = mr_low ? RSS_ST_RESET : RSS_ST_HELD;
      end
      RSS_ST_HELD: begin
        if (mr_low) begin
          state_next = RSS_ST_RESET;
        end
      end
      default: begin
        state_next = RSS_ST_IDLE;
      end
    endcase
  end

  wire do_capture = (state_reg == RSS_ST_RESET) && mr_rise;
  wire do_derive  = (state_reg == RSS_ST_CAPTURE);
  wire in_reset   = (state_reg == RSS_ST_RESET);
  wire enter_rst  = (state_reg != RSS_ST_RESET) && (state_next == RSS_ST_RESET);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= RSS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Strap latch only loads on the rising edge of master reset
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_reg <= '0;
    end else if (do_capture) begin
      strap_reg <= gpio_s2_reg;   // [R1] [R20]
    end
  end

  // Unprogrammed parts fall back to default pin roles
  wire [NG-1:0] def_sel_mask = NG'(`RSS_DEF_SEL_MASK);
  wire [NG-1:0] eff_addr_mask;
  wire [NG-1:0] eff_eeprom_mask;
  wire [NG-1:0] eff_sel_mask;
  wire          sel_none = ~|info_cfg_sel_mask;

  assign eff_addr_mask   = info_has_user_cfg ? info_addr_mask : '0;         // [R16]
  assign eff_eeprom_mask = info_has_user_cfg ? info_eeprom_dis_mask : '0;   // [R16] [R9]
  // Empty select mask means GPIO[3:0], which pulls up to fifteen
  assign eff_sel_mask    = (info_has_user_cfg && !sel_none) ? info_cfg_sel_mask
                                                            : def_sel_mask;   // [R11] [R12] [R16]

  rss_sel_if #(.NG(NG)) sel_bus ();

  assign sel_bus.strap       = strap_reg;
  assign sel_bus.addr_mask   = eff_addr_mask;
  assign sel_bus.eeprom_mask = eff_eeprom_mask;
  assign sel_bus.sel_mask    = eff_sel_mask;

  rss_select #(.NG(NG)) u_select (
    .sif (sel_bus.calc)
  );

  wire strap_main_i2c = strap_reg[`RSS_PORT_SEL_PIN];

  // Derived settings; capture path wins over a same-cycle write
  logic          main_i2c_reg;
  logic          a2_reg;
  logic          eeprom_en_reg;
  logic [NG-1:0] index_reg;
  logic          index_valid_reg;
  logic          captured_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      main_i2c_reg    <= `RSS_RST_MAIN_I2C;
      a2_reg          <= `RSS_RST_A2;
      eeprom_en_reg   <= `RSS_RST_EEPROM_EN;
      index_reg       <= '0;
      index_valid_reg <= 1'b0;
      captured_reg    <= 1'b0;
    end else if (do_derive) begin
      main_i2c_reg    <= strap_main_i2c;          // [R2]
      a2_reg          <= sel_bus.a2;              // [R5] [R6]
      eeprom_en_reg   <= ~sel_bus.eeprom_dis;     // [R8] [R9] [R10]
      index_reg       <= sel_bus.index;           // [R11] [R13] [R14] [R15]
      // Reset seen again while deriving: nothing counts as captured
      index_valid_reg <= info_has_user_cfg && !enter_rst;   // [R16]
      captured_reg    <= !enter_rst;
    end else begin
      if (enter_rst) begin
        captured_reg    <= 1'b0;
        index_valid_reg <= 1'b0;
      end
      if (wr_port_swap_we) begin
        main_i2c_reg <= wr_port_swap;   // [R4]
      end
      if (wr_a2_we) begin
        a2_reg <= wr_a2;   // [R4]
      end
      if (wr_eeprom_en_we) begin
        eeprom_en_reg <= wr_eeprom_en;   // [R4]
      end
      if (wr_index_we) begin
        index_reg <= wr_index;   // [R4]
      end
    end
  end

  // Load decision; a failed checksum leaves every default in place
  logic load_en_reg;
  logic load_skip_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      load_en_reg   <= 1'b0;
      load_skip_reg <= 1'b0;
    end else if (enter_rst || do_derive) begin
      load_en_reg   <= 1'b0;
      load_skip_reg <= 1'b0;
    end else if (cfg_check_done && index_valid_reg && !load_en_reg && !load_skip_reg) begin
      load_en_reg   <= cfg_check_ok;    // [R19]
      load_skip_reg <= ~cfg_check_ok;   // [R19]
    end
  end

  // Neutral defaults; only software writes open clocks or GPIO drivers
  logic [NC-1:0] clk_en_reg;
  logic [NG-1:0] gpio_oe_reg;

  always_ff @(posedge clk) begin
    if (srst || enter_rst) begin
      clk_en_reg  <= {NC{`RSS_RST_CLK_OUT_EN}};    // [R17]
      gpio_oe_reg <= {NG{`RSS_RST_GPIO_OUT_EN}};   // [R17]
    end else begin
      if (wr_clk_out_we) begin
        clk_en_reg <= wr_clk_out_en;   // [R4]
      end
      if (wr_gpio_mode_we) begin
        gpio_oe_reg <= wr_gpio_out_en;   // [R4]
      end
    end
  end

  // Board-side check: pin 8 low while in reset; set beats the clear
  logic fault_reg;
  // Only while reset is still low; pin 8 is free once reset has risen
  wire  fault_set = in_reset && mr_low && !gpio_s2_reg[`RSS_HOLD_HIGH_PIN];   // [R3]

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_reg <= 1'b0;
    end else if (fault_set) begin
      fault_reg <= 1'b1;
    end else if (enter_rst) begin
      fault_reg <= 1'b0;
    end
  end

  // Output flops; A2 reaches only the port that speaks I2C
  always_ff @(posedge clk) begin
    if (srst) begin
      main_is_i2c      <= `RSS_RST_MAIN_I2C;
      aux_is_i2c       <= ~`RSS_RST_MAIN_I2C;
      main_addr_a2     <= 1'b0;
      aux_addr_a2      <= 1'b0;
      eeprom_search_en <= `RSS_RST_EEPROM_EN;
      cfg_index        <= '0;
      cfg_index_valid  <= 1'b0;
      cfg_load_en      <= 1'b0;
      cfg_load_skipped <= 1'b0;
      strap_captured   <= 1'b0;
      hold_pin_fault   <= 1'b0;
      clk_out_en       <= {NC{`RSS_RST_CLK_OUT_EN}};
      gpio_out_en      <= {NG{`RSS_RST_GPIO_OUT_EN}};
    end else begin
      main_is_i2c      <= main_i2c_reg;               // [R2]
      aux_is_i2c       <= ~main_i2c_reg;              // [R2]
      main_addr_a2     <= main_i2c_reg & a2_reg;      // [R7]
      aux_addr_a2      <= ~main_i2c_reg & a2_reg;     // [R7]
      eeprom_search_en <= eeprom_en_reg;
      cfg_index        <= index_reg;
      cfg_index_valid  <= index_valid_reg;
      cfg_load_en      <= load_en_reg;
      cfg_load_skipped <= load_skip_reg;
      strap_captured   <= captured_reg;
      hold_pin_fault   <= fault_reg;
      clk_out_en       <= clk_en_reg;
      gpio_out_en      <= gpio_oe_reg;
    end
  end

endmodule

// ### tb/rss_top_checker.sv
module rss_top_checker
  import rss_pkg::*;
#(
  parameter int NG = 16,
  parameter int NC = 8
) (
  input wire logic          clk,
  input wire logic          srst,
  input wire logic          master_reset_low,
  input wire logic          info_has_user_cfg,
  input wire logic          cfg_check_done,
  input wire logic          cfg_check_ok,
  input wire logic          wr_port_swap_we,
  input wire logic          wr_clk_out_we,
  input wire logic [NC-1:0] wr_clk_out_en,
  input wire logic          main_is_i2c,
  input wire logic          aux_is_i2c,
  input wire logic          main_addr_a2,
  input wire logic          aux_addr_a2,
  input wire logic          cfg_index_valid,
  input wire logic          cfg_load_en,
  input wire logic          cfg_load_skipped,
  input wire logic          strap_captured,
  input wire logic [NC-1:0] clk_out_en,
  input wire logic [NG-1:0] gpio_out_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_rise;
    $rose(master_reset_low);
  endsequence
  sequence s_bad_sum;
    cfg_check_done && !cfg_check_ok && cfg_index_valid && !cfg_load_en && !cfg_load_skipped;
  endsequence

  chk_capture_time: assert property (s_rise |-> ##[4:6] strap_captured)
    else $error("straps not captured in time");
  chk_port_pair: assert property (aux_is_i2c == !main_is_i2c)
    else $error("both ports share a protocol");
  chk_spi_no_a2: assert property (!(main_addr_a2 && !main_is_i2c) && !(aux_addr_a2 && !aux_is_i2c))
    else $error("address bit on an SPI port");
  chk_straps_hold: assert property (strap_captured && $past(strap_captured)
    && !$past(wr_port_swap_we, 2) && !$past(wr_port_swap_we, 3) |-> $stable(main_is_i2c))
    else $error("captured setting drifted");
  chk_reset_clears: assert property ($fell(master_reset_low) |->
    ##[3:6] (clk_out_en == '0 && gpio_out_en == '0 && !strap_captured))
    else $error("enables not cleared by master reset");
  chk_write_delay: assert property (wr_clk_out_we && master_reset_low |->
    ##[2:3] clk_out_en == wr_clk_out_en)
    else $error("write not applied");
  chk_bad_sum: assert property (s_bad_sum |-> ##[1:3] (cfg_load_skipped && !cfg_load_en))
    else $error("failed checksum not skipped");
  chk_no_user_cfg: assert property (strap_captured && !info_has_user_cfg |->
    !cfg_index_valid && !cfg_load_en)
    else $error("index used without user configs");
endmodule

bind rss_top rss_top_checker #(.NG(NG), .NC(NC)) u_chk (.clk, .srst, .master_reset_low,
  .info_has_user_cfg, .cfg_check_done, .cfg_check_ok, .wr_port_swap_we, .wr_clk_out_we,
  .wr_clk_out_en, .main_is_i2c, .aux_is_i2c, .main_addr_a2, .aux_addr_a2, .cfg_index_valid,
  .cfg_load_en, .cfg_load_skipped, .strap_captured, .clk_out_en, .gpio_out_en);

// ### tb/rss_board_model.sv
`include "rss_defines.svh"

module rss_board_model #(
  parameter int NG = 16
) (
  input wire logic          master_reset_low,
  input wire logic [NG-1:0] drv,
  input wire logic [NG-1:0] oe,
  output logic     [NG-1:0] gpio
);
  timeunit 1ns;
  timeprecision 100ps;
  // Undriven pins sit at the internal pull-up level
  logic [NG-1:0] pulled;
  assign pulled = (drv & oe) | ~oe;
  // Test-access pins never carry strap duty here
  always_comb begin
    gpio = pulled;
    if (!master_reset_low) gpio[`RSS_HOLD_HIGH_PIN] = 1'b1;
  end
endmodule

// ### tb/reset_strap_sampler_tb_top.sv
module reset_strap_sampler_tb_top
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] am, em, sm, oe, pin, idx;
    logic        hu;
    logic [3:0]  fl;
  } rss_row_t;
  // Flags: main is I2C, A2, EEPROM search, index valid
  localparam rss_row_t ROWS [6] = '{
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000F, 1'b1, 4'hB},
    '{16'h00A0, 16'h0006, 16'h0000, 16'hFFFF, 16'h0125, 16'h0005, 1'b1, 4'h1},
    '{16'h0088, 16'h0000, 16'h0164, 16'hFFFF, 16'h03C4, 16'h000D, 1'b1, 4'hF},
    '{16'h8000, 16'h0000, 16'h0C00, 16'hFFFF, 16'h8900, 16'h0002, 1'b1, 4'h7},
    '{16'h0000, 16'h4000, 16'h00FF, 16'hFFFF, 16'h41A5, 16'h00A5, 1'b1, 4'h1},
    '{16'h0001, 16'h0002, 16'h00F0, 16'hFFFF, 16'h0303, 16'h0000, 1'b0, 4'hA}};
  logic        clk = 1'b0;
  logic        srst, master_reset_low, info_has_user_cfg, cfg_check_done, cfg_check_ok;
  logic        wr_port_swap_we, wr_port_swap, wr_a2_we, wr_a2, wr_eeprom_en_we, wr_eeprom_en;
  logic        wr_index_we, wr_clk_out_we, wr_gpio_mode_we;
  logic [15:0] gpio_pin_in, info_addr_mask, info_eeprom_dis_mask, info_cfg_sel_mask, drv, oe;
  logic [15:0] wr_index, wr_gpio_out_en, cfg_index, gpio_out_en;
  logic [7:0]  wr_clk_out_en, clk_out_en;
  logic        main_is_i2c, aux_is_i2c, main_addr_a2, aux_addr_a2, eeprom_search_en;
  logic        cfg_index_valid, cfg_load_en, cfg_load_skipped, strap_captured, hold_pin_fault;
  int          error_cnt = 0;
  int          total_checks = 0;
  rss_row_t    r;

  always #12.5 clk = ~clk;

  rss_board_model #(.NG(16)) u_board (.master_reset_low, .drv, .oe, .gpio(gpio_pin_in));

  rss_top #(.NG(16), .NC(8)) DUT (.clk, .srst, .master_reset_low, .gpio_pin_in, .info_addr_mask,
    .info_eeprom_dis_mask, .info_cfg_sel_mask, .info_has_user_cfg, .cfg_check_done, .cfg_check_ok,
    .wr_port_swap_we, .wr_port_swap, .wr_a2_we, .wr_a2, .wr_eeprom_en_we, .wr_eeprom_en, .wr_index_we,
    .wr_index, .wr_clk_out_we, .wr_clk_out_en, .wr_gpio_mode_we, .wr_gpio_out_en, .main_is_i2c,
    .aux_is_i2c, .main_addr_a2, .aux_addr_a2, .eeprom_search_en, .cfg_index, .cfg_index_valid,
    .cfg_load_en, .cfg_load_skipped, .strap_captured, .hold_pin_fault, .clk_out_en, .gpio_out_en);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Straps change late in reset, so the old capture is gone first
  task automatic mres;
    master_reset_low = 1'b0;
    repeat (5) @(negedge clk);
    {info_addr_mask, info_eeprom_dis_mask, info_cfg_sel_mask, oe, drv} = {r.am, r.em, r.sm, r.oe, r.pin};
    info_has_user_cfg = r.hu;
    @(negedge clk);
    master_reset_low = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic sum(input logic good);
    cfg_check_done = 1'b1;
    cfg_check_ok = good;
    @(negedge clk);
    cfg_check_done = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    {srst, master_reset_low, info_has_user_cfg} = 3'h7;
    {cfg_check_done, cfg_check_ok, drv, oe} = '0;
    {info_addr_mask, info_eeprom_dis_mask, info_cfg_sel_mask} = '0;
    {wr_port_swap_we, wr_a2_we, wr_eeprom_en_we, wr_index_we, wr_clk_out_we, wr_gpio_mode_we} = 6'h00;
    {wr_port_swap, wr_a2, wr_eeprom_en, wr_index, wr_clk_out_en, wr_gpio_out_en} = '0;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk({main_is_i2c, aux_is_i2c, eeprom_search_en}, 16'h0003);
    chk(cfg_index | gpio_out_en | clk_out_en, 16'h0000);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      mres();
      chk({main_is_i2c, aux_is_i2c}, {r.fl[3], ~r.fl[3]});
      chk({main_addr_a2, aux_addr_a2}, {r.fl[3] & r.fl[2], ~r.fl[3] & r.fl[2]});
      chk(eeprom_search_en, r.fl[1]);
      chk({cfg_index_valid, strap_captured, hold_pin_fault}, {r.fl[0], 2'b10});
      if (r.fl[0]) chk(cfg_index, r.idx);
      drv = ~drv;
      repeat (4) @(negedge clk);
      if (r.fl[0]) chk(cfg_index, r.idx);
    end
    r = ROWS[0];
    mres();
    sum(1'b0);
    chk({cfg_load_en, cfg_load_skipped}, 16'h0001);
    sum(1'b1);
    chk({cfg_load_en, cfg_load_skipped}, 16'h0001);
    mres();
    sum(1'b1);
    chk({cfg_load_en, cfg_load_skipped}, 16'h0002);
    {wr_port_swap, wr_a2, wr_eeprom_en} = 3'h2;
    {wr_index, wr_clk_out_en, wr_gpio_out_en} = {16'h1234, 8'hA5, 16'h00F0};
    {wr_port_swap_we, wr_a2_we, wr_eeprom_en_we, wr_index_we, wr_clk_out_we, wr_gpio_mode_we} = 6'h3F;
    @(negedge clk);
    {wr_port_swap_we, wr_a2_we, wr_eeprom_en_we, wr_index_we, wr_clk_out_we, wr_gpio_mode_we} = 6'h00;
    repeat (4) @(negedge clk);
    chk({main_is_i2c, main_addr_a2, aux_addr_a2, eeprom_search_en}, 16'h0002);
    chk(cfg_index, 16'h1234);
    chk({clk_out_en, gpio_out_en[7:0]}, 16'hA5F0);
    master_reset_low = 1'b0;
    repeat (6) @(negedge clk);
    chk({clk_out_en, gpio_out_en[7:0]}, 16'h0000);
    chk(strap_captured, 16'h0000);
    master_reset_low = 1'b1;
    repeat (8) @(negedge clk);
    wrap_up();
  end

  // Whole sequence needs about 190 cycles
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule
